// ==== core/fpe_ctrl.sv ====
/*
  Flash program/erase controller: APB control register, sequencer,
  regulator idle handling and interrupt.
  Assumes the flash array reports an abort on flash_abort and that
  idle_mode is a synchronous level from the power manager.
*/
`timescale 1ns/1ps

module fpe_ctrl
  import fpe_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        idle_mode,
  input  wire logic        flash_abort,
  output logic             flash_erase_active,
  output logic             flash_program_active,
  output logic             regulator_standby,
  output logic             flash_usable,
  output logic             power_save_block,
  output logic             irq
);

  fpe_timer_if tmr ();

  fpe_timer u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tmr     (tmr.timer)
  );

  // Valid operation codes
  function automatic logic op_valid(input logic [3:0] op);
    return (op == FPE_OP_PAGE_ERASE) || (op == FPE_OP_DWORD_PROG);
  endfunction

  fpe_state_type state_q, state_d;
  logic          start_q;
  logic          permit_q;
  logic          err_q;
  logic          istop_q;
  logic [3:0]    op_q;
  logic [1:0]    stat_q, mask_q;
  logic [31:0]   prdata_q;
  logic          erase_q, prog_q, stby_q, usable_q, psblk_q;

  // ==========================================================
  // APB decode: zero wait states, unmapped addresses answer an error
  logic access, wr_acc, setup;
  logic hit_ctrl, hit_stat, hit_mask, hit_state, hit_any;
  logic ctrl_wr, stat_wr, mask_wr;
  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign wr_acc    = access && pwrite;
  assign hit_ctrl  = (paddr == FPE_OFS_CTRL);
  assign hit_stat  = (paddr == FPE_OFS_STAT);
  assign hit_mask  = (paddr == FPE_OFS_MASK);
  assign hit_state = (paddr == FPE_OFS_STATE);
  assign hit_any   = hit_ctrl || hit_stat || hit_mask || hit_state;
  assign ctrl_wr   = wr_acc && hit_ctrl;
  assign stat_wr   = wr_acc && hit_stat;
  assign mask_wr   = wr_acc && hit_mask;
  assign pready    = 1'b1;
  assign pslverr   = access && !hit_any;

  // Read data image of the control register
  logic [15:0] ctrl_img;
  assign ctrl_img = {start_q, permit_q, err_q, istop_q, 8'h00, op_q};

  logic [31:0] rd_mux;
  always_comb begin
    if (hit_ctrl) begin
      rd_mux = {16'h0000, ctrl_img};
    end else if (hit_stat) begin
      rd_mux = {30'h0, stat_q};
    end else if (hit_mask) begin
      rd_mux = {30'h0, mask_q};
    end else if (hit_state) begin
      rd_mux = {28'h0, stby_q, usable_q, state_q};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Read data captured in the setup phase so it is a flop in the access phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end
  assign prdata = prdata_q;

  // ==========================================================
  // Start attempts and sequence checks
  logic start_try, bad_seq, start_ok, term_bad, hw_abort, err_set;
  logic running, done_pulse, abort_run;
  assign running = (state_q == FPE_ST_RUN);
  assign start_try = ctrl_wr && pwdata[FPE_CTL_START] && !start_q;
  assign bad_seq  = start_try && (!pwdata[FPE_CTL_PERMIT] || !op_valid(pwdata[3:0]));
  assign start_ok = start_try && !bad_seq;
  assign term_bad = ctrl_wr && !pwdata[FPE_CTL_START] && start_q;
  assign hw_abort = running && flash_abort;
  assign abort_run = term_bad || hw_abort;
  assign err_set  = bad_seq || abort_run;
  assign done_pulse = running && tmr.expired && !abort_run;

  // ==========================================================
  // Control register; permit and operation fields locked while an operation is pending
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_q  <= FPE_CTRL_RESET[FPE_CTL_START];
      permit_q <= FPE_CTRL_RESET[FPE_CTL_PERMIT];
      istop_q  <= FPE_CTRL_RESET[FPE_CTL_ISTOP];
      op_q     <= FPE_CTRL_RESET[3:0];
    end else begin
      if (done_pulse || abort_run) begin
        start_q <= 1'b0;
      end else if (start_ok) begin
        start_q <= 1'b1;
      end
      if (ctrl_wr && !start_q) begin
        permit_q <= pwdata[FPE_CTL_PERMIT];
        op_q     <= pwdata[3:0];
      end
      if (ctrl_wr) begin
        istop_q <= pwdata[FPE_CTL_ISTOP];
      end
    end
  end

  // Error flag: hardware set wins over a software clear
  // completion never sets it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_q <= FPE_CTRL_RESET[FPE_CTL_ERR];
    end else if (err_set) begin
      err_q <= 1'b1;
    end else if (ctrl_wr && !pwdata[FPE_CTL_ERR]) begin
      err_q <= 1'b0;
    end
  end

  // ==========================================================
  // Sequencer
  logic load_op, load_wake;
  always_comb begin
    state_d   = state_q;
    load_op   = 1'b0;
    load_wake = 1'b0;
    case (state_q)
      FPE_ST_IDLE: begin
        if (start_q && !term_bad) begin
          state_d = FPE_ST_RUN;
          load_op = 1'b1;
        end else if (idle_mode && istop_q) begin
          state_d = FPE_ST_STANDBY;
        end
      end
      FPE_ST_RUN: begin
        if (done_pulse || abort_run) begin
          state_d = FPE_ST_IDLE;
        end
      end
      FPE_ST_STANDBY: begin
        if (!idle_mode) begin
          state_d   = FPE_ST_WAKE;
          load_wake = 1'b1;
        end
      end
      FPE_ST_WAKE: begin
        if (tmr.expired) begin
          state_d = FPE_ST_IDLE;
        end
      end
      default: begin
        state_d = FPE_ST_IDLE;
      end
    endcase
  end

  assign tmr.load       = load_op || load_wake;
  assign tmr.load_value = load_op ? FPE_OP_CYCLES : FPE_WAKE_CYCLES;
  // Only an aborted operation may stop the timer; a start withdrawn during
  // the wake-up delay must leave that delay running, or the sequencer stalls
  assign tmr.cancel     = running && abort_run;

  // State and output flops follow the next state so outputs match it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q  <= FPE_ST_IDLE;
      erase_q  <= 1'b0;
      prog_q   <= 1'b0;
      stby_q   <= 1'b0;
      usable_q <= 1'b1;
      psblk_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      erase_q  <= (state_d == FPE_ST_RUN) && (op_q == FPE_OP_PAGE_ERASE);
      prog_q   <= (state_d == FPE_ST_RUN) && (op_q == FPE_OP_DWORD_PROG);
      stby_q   <= (state_d == FPE_ST_STANDBY);
      usable_q <= (state_d == FPE_ST_IDLE) || (state_d == FPE_ST_RUN);
      psblk_q  <= (state_d == FPE_ST_RUN);
    end
  end

  assign flash_erase_active   = erase_q;
  assign flash_program_active = prog_q;
  assign regulator_standby    = stby_q;
  assign flash_usable         = usable_q;
  assign power_save_block     = psblk_q;

  // ==========================================================
  // Interrupts: sticky status, write one to clear, set wins
  logic [1:0] stat_set;
  assign stat_set = {err_set, done_pulse};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_q <= FPE_INT_RESET;
      mask_q <= FPE_INT_RESET;
    end else begin
      stat_q <= stat_set | (stat_q & ~(stat_wr ? pwdata[1:0] : 2'h0));
      if (mask_wr) begin
        mask_q <= pwdata[1:0];
      end
    end
  end
  assign irq = |(stat_q & mask_q);

  // ==========================================================
  // Checks
  localparam logic [15:0] OP_LAST   = FPE_OP_CYCLES - 16'h0001;
  localparam logic [15:0] WAKE_LAST = FPE_WAKE_CYCLES - 16'h0001;
  logic [15:0] run_cnt_q;
  always_ff @(posedge clk) begin
    if (sys_rst || !running) begin
      run_cnt_q <= 16'h0000;
    end else begin
      run_cnt_q <= run_cnt_q + 16'h0001;
    end
  end

  // Helper count of cycles spent in the wake-up delay
  logic [15:0] wake_cnt_q;
  always_ff @(posedge clk) begin
    if (sys_rst || state_q != FPE_ST_WAKE) begin
      wake_cnt_q <= 16'h0000;
    end else begin
      wake_cnt_q <= wake_cnt_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_blocked_start: assert property (
    start_try && !pwdata[FPE_CTL_PERMIT] |=> !start_q && err_q && !running)
    else $error("start accepted without permit");
  a_bad_sets_err: assert property (
    abort_run |=> err_q && stat_q[FPE_INT_ERR] && !running)
    else $error("improper termination not flagged");
  a_try_judged: assert property (
    start_try && !op_valid(pwdata[3:0]) |=> err_q ##1 !running)
    else $error("reserved code start not flagged");
  a_normal_clean: assert property (
    done_pulse && !err_q && !err_set && !ctrl_wr |=> !err_q && stat_q[FPE_INT_DONE])
    else $error("normal completion disturbed error flag");
  a_wake_delay: assert property (
    state_q == FPE_ST_STANDBY && !idle_mode |=> !flash_usable [*8])
    else $error("flash usable before wake-up delay");
  a_wake_length: assert property (
    state_q == FPE_ST_WAKE && tmr.expired |-> wake_cnt_q == WAKE_LAST)
    else $error("wake-up delay length wrong");
  a_wake_unusable: assert property (
    state_q == FPE_ST_WAKE |-> !flash_usable && !regulator_standby)
    else $error("flash usable or regulator asleep during wake-up");
  a_wake_timer: assert property (
    state_q == FPE_ST_WAKE |-> tmr.running)
    else $error("wake-up delay without a running timer");
  a_op_length: assert property (
    done_pulse |-> run_cnt_q == OP_LAST ##1 !start_q)
    else $error("operation length or start clear wrong");
  a_start_runs: assert property (
    state_q == FPE_ST_IDLE && start_q && !term_bad |=> running && psblk_q)
    else $error("pending start did not run");
  a_op_decode: assert property (
    running |-> op_valid(op_q) && (flash_erase_active != flash_program_active))
    else $error("running with reserved operation");
  a_irq_level: assert property (
    (stat_q[FPE_INT_DONE] && mask_q[FPE_INT_DONE]) |-> irq)
    else $error("masked-in status without interrupt");

  c_normal_op: cover property (done_pulse ##1 !err_q);
  c_blocked:   cover property (bad_seq);
  c_wake:      cover property (state_q == FPE_ST_WAKE ##1 state_q == FPE_ST_IDLE);
  c_abort:     cover property (running && flash_abort);

endmodule

// ==== core/fpe_pkg.sv ====
/*
  Constants and types shared by the flash program/erase controller.
  Assumes a 20 MHz system clock and a 32-bit APB register bus.
*/
package fpe_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] FPE_OFS_CTRL  = 8'h00;
  localparam logic [7:0] FPE_OFS_STAT  = 8'h04;
  localparam logic [7:0] FPE_OFS_MASK  = 8'h08;
  localparam logic [7:0] FPE_OFS_STATE = 8'h0c;

  // ==========================================================
  // Control register fields
  localparam int unsigned FPE_CTL_START  = 15;
  localparam int unsigned FPE_CTL_PERMIT = 14;
  localparam int unsigned FPE_CTL_ERR    = 13;
  localparam int unsigned FPE_CTL_ISTOP  = 12;
  localparam int unsigned FPE_CTL_OP_LSB = 0;
  localparam int unsigned FPE_OP_W       = 4;
  localparam logic [15:0] FPE_CTRL_RESET = 16'h0000;

  // Operation codes; every other code is reserved
  localparam logic [3:0] FPE_OP_PAGE_ERASE = 4'h3;
  localparam logic [3:0] FPE_OP_DWORD_PROG = 4'h1;

  // ==========================================================
  // Interrupt status / mask fields
  localparam int unsigned FPE_INT_W    = 2;
  localparam int unsigned FPE_INT_DONE = 0;
  localparam int unsigned FPE_INT_ERR  = 1;
  localparam logic [1:0]  FPE_INT_RESET = 2'h0;

  // ==========================================================
  // Timing
  localparam int unsigned FPE_CLK_PERIOD_NS = 50;
  localparam int unsigned FPE_OP_TIME_NS    = 20000;
  localparam int unsigned FPE_WAKE_TIME_NS  = 10000;
  localparam int unsigned FPE_TMR_W         = 16;

  // Least time rounded up to whole cycles, never below one
  function automatic logic [15:0] fpe_cycles_ceil(input int unsigned ns);
    int unsigned c;
    c = (ns + FPE_CLK_PERIOD_NS - 1) / FPE_CLK_PERIOD_NS;
    if (c == 0) begin
      c = 1;
    end
    return c[15:0];
  endfunction

  localparam logic [15:0] FPE_OP_CYCLES   = fpe_cycles_ceil(FPE_OP_TIME_NS);
  localparam logic [15:0] FPE_WAKE_CYCLES = fpe_cycles_ceil(FPE_WAKE_TIME_NS);

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    FPE_ST_IDLE,
    FPE_ST_RUN,
    FPE_ST_STANDBY,
    FPE_ST_WAKE
  } fpe_state_type;

endpackage

// ==== core/fpe_timer_if.sv ====
/*
  Link between the sequencer and its down-counting timer.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface fpe_timer_if;
  logic        load;
  logic        cancel;
  logic [15:0] load_value;
  logic        expired;
  logic        running;

  modport ctrl  (output load, output cancel, output load_value, input expired, input running);
  modport timer (input load, input cancel, input load_value, output expired, output running);
endinterface

// ==== core/fpe_timer.sv ====
/*
  Down-counting timer for self-timed operations and regulator wake-up.
  Assumes a load value of at least one; expiry is a one-cycle pulse.
*/
`timescale 1ns/1ps
module fpe_timer
  import fpe_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  fpe_timer_if.timer tmr
);

  logic [FPE_TMR_W-1:0] cnt_q;
  logic                 run_q;
  logic                 last;

  // Expiry on the final counted cycle
  assign last        = run_q && (cnt_q == 16'h0001);
  assign tmr.expired = last && !tmr.cancel;
  assign tmr.running = run_q;

  // ==========================================================
  // Counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
    end else if (tmr.load) begin
      cnt_q <= tmr.load_value;
      run_q <= 1'b1;
    end else if (tmr.cancel || last) begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
    end else if (run_q) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

endmodule

// ==== tb/flash_program_erase_control_test.sv ====
/*
  Self-checking bench for the flash program/erase controller (fpe_ctrl).
  Assumes the fpe_pkg register map and a zero-wait APB slave.
*/
`timescale 1ns/1ps
module flash_program_erase_control_test;
  import fpe_pkg::*;

  // ==========================================================
  // Notes and signals
  typedef struct {
    logic [31:0] data;
    logic [31:0] mask;
    logic [6:0]  flg;
  } fpe_note_type;
  // Flags: pslverr, irq, erase, program, power-save block, standby, usable
  localparam logic [6:0] F_U = 7'h01, F_IU = 7'h21, F_SLV = 7'h41;
  localparam logic [6:0] F_ERA = 7'h15, F_PRG = 7'h0d, F_STB = 7'h02;
  localparam logic [31:0] M_ALL = 32'hffffffff;

  logic        clk, sys_rst, psel, penable, pwrite, idle_mode, flash_abort;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, f_era, f_prg, r_stb, f_use, p_blk, irq;
  logic [15:0] rnd;
  int          fail_count, tests_run;
  fpe_note_type notes[$];
  fpe_note_type cur;

  fpe_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .idle_mode(idle_mode), .flash_abort(flash_abort),
    .flash_erase_active(f_era), .flash_program_active(f_prg),
    .regulator_standby(r_stb), .flash_usable(f_use), .power_save_block(p_blk), .irq(irq));

  // ==========================================================
  // Clock, random source, check and verdict
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // APB master: one transfer, request held until pready is seen
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rnd = lfsr_next(rnd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    // Upper half is random: only the low half of each register is real
    pwdata  <= {rnd, d[15:0]};
    @(posedge clk);
    penable <= 1'b1;
    forever begin
      @(posedge clk);
      if (pready === 1'b1) break;
      if (++n > 50) begin
        fail_count++;
        results();
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // The expected answer is queued before the read goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [6:0] f);
    notes.push_back('{d, m, f});
    xfer(1'b0, a, 32'h0);
  endtask

  // ==========================================================
  // Monitor: mid access phase, so every output has settled
  always @(negedge clk) begin
    if (sys_rst === 1'b0 && psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0) begin
      if (notes.size() == 0) begin
        chk("note queue", 32'h1, 32'h0);
      end else begin
        cur = notes.pop_front();
        chk("prdata", prdata & cur.mask, cur.data);
        chk("flags", {25'h0, pslverr, irq, f_era, f_prg, p_blk, r_stb, f_use},
            {25'h0, cur.flg});
      end
    end
  end

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end

  // ==========================================================
  // Main sequence
  initial begin
    fail_count = 0;
    tests_run  = 0;
    rnd = 16'h0031;
    {psel, penable, pwrite, idle_mode, flash_abort} = 5'h00;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values, unmapped address refused
    rd(FPE_OFS_CTRL, 32'h0, M_ALL, F_U);
    rd(FPE_OFS_STAT, 32'h0, M_ALL, F_U);
    rd(FPE_OFS_MASK, 32'h0, M_ALL, F_U);
    rd(FPE_OFS_STATE, 32'h4, M_ALL, F_U);
    rd(8'h10, 32'h0, M_ALL, F_SLV);
    // start without permit is blocked and flagged
    wr(FPE_OFS_CTRL, 32'h8003);
    rd(FPE_OFS_CTRL, 32'h2003, M_ALL, F_U);
    rd(FPE_OFS_STAT, 32'h2, M_ALL, F_U);
    wr(FPE_OFS_MASK, 32'h3);
    rd(FPE_OFS_STAT, 32'h2, M_ALL, F_IU);
    wr(FPE_OFS_STAT, 32'h3);
    rd(FPE_OFS_STAT, 32'h0, M_ALL, F_U);
    for (int op = 0; op < 16; op++) begin
      wr(FPE_OFS_CTRL, 32'h0);
      wr(FPE_OFS_STAT, 32'h3);
      wr(FPE_OFS_CTRL, 32'hc000 | op);
      repeat (3) @(posedge clk);
      if (op == 3 || op == 1) begin
        rd(FPE_OFS_CTRL, 32'hc000 | op, M_ALL, (op == 3) ? F_ERA : F_PRG);
        rd(FPE_OFS_STATE, 32'h5, M_ALL, (op == 3) ? F_ERA : F_PRG);
        repeat (410) @(posedge clk);
        rd(FPE_OFS_CTRL, 32'h4000 | op, M_ALL, F_IU);
        rd(FPE_OFS_STAT, 32'h1, M_ALL, F_IU);
      end else begin
        rd(FPE_OFS_CTRL, 32'h6000 | op, M_ALL, F_IU);
        rd(FPE_OFS_STAT, 32'h2, M_ALL, F_IU);
      end
    end
    // operations aborted by clearing start at a random moment and by flash_abort
    wr(FPE_OFS_CTRL, 32'h0);
    wr(FPE_OFS_STAT, 32'h3);
    wr(FPE_OFS_CTRL, 32'hc001);
    repeat (5 + rnd[5:0]) @(posedge clk);
    wr(FPE_OFS_CTRL, 32'h4001);
    rd(FPE_OFS_CTRL, 32'h6001, M_ALL, F_IU);
    rd(FPE_OFS_STAT, 32'h2, M_ALL, F_IU);
    wr(FPE_OFS_CTRL, 32'h0);
    wr(FPE_OFS_STAT, 32'h3);
    wr(FPE_OFS_CTRL, 32'hc003);
    repeat (5) @(posedge clk);
    flash_abort <= 1'b1;
    @(posedge clk);
    flash_abort <= 1'b0;
    repeat (3) @(posedge clk);
    rd(FPE_OFS_CTRL, 32'h6003, M_ALL, F_IU);
    rd(FPE_OFS_STAT, 32'h2, M_ALL, F_IU);
    // regulator stays on in idle unless idle stop is set
    wr(FPE_OFS_CTRL, 32'h0);
    wr(FPE_OFS_STAT, 32'h3);
    idle_mode <= 1'b1;
    repeat (4) @(posedge clk);
    rd(FPE_OFS_STATE, 32'h4, M_ALL, F_U);
    wr(FPE_OFS_CTRL, 32'h1000);
    repeat (4) @(posedge clk);
    rd(FPE_OFS_STATE, 32'ha, M_ALL, F_STB);
    idle_mode <= 1'b0;
    repeat (3) @(posedge clk);
    rd(FPE_OFS_STATE, 32'h3, M_ALL, 7'h00);
    // a start queued during the wake-up delay and then withdrawn
    wr(FPE_OFS_CTRL, 32'hd001);
    wr(FPE_OFS_CTRL, 32'h1000);
    rd(FPE_OFS_CTRL, 32'h7001, M_ALL, 7'h20);
    repeat (205) @(posedge clk);
    rd(FPE_OFS_STATE, 32'h4, M_ALL, F_IU);
    repeat (3) @(posedge clk);
    results();
  end
endmodule
